// *** rtl/scts_supervisor.sv ***
`timescale 1ns/10ps
`include "scts_regs.svh"
module scts_supervisor #(
   parameter int unsigned OT_FLT_CYC = `SCTS_OT_FLT_CYC,
   parameter int unsigned PWRUP_CYC  = `SCTS_PWRUP_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire scts_pkg::scts_mon_t     mon,
   input  wire logic                    osc_main_ok,
   input  wire logic                    sd_bit,
   input  wire logic                    sd_bit_valid,
   input  wire logic                    ssm_disable,
   input  wire logic                    temp_reg_read,
   output logic                         primary_reset_out_n,
   output logic                         secondary_reset_out_n,
   output logic                         outputs_enable,
   output logic                         charge_pump_enable,
   output logic                         regs_reset,
   output logic                         osc_use_redundant,
   output logic [5:0]                   ssm_level,
   output scts_pkg::scts_temp_reg_t     temp_reg
);
   import scts_pkg::*;

   localparam int unsigned OTW = $clog2(OT_FLT_CYC + 1);
   localparam int unsigned PUW = $clog2(PWRUP_CYC + 1);

   // two-stage synchronisers for analog monitor levels
   scts_mon_t   mon_s1_q;
   scts_mon_t   mon_s2_q;
   logic [2:0]  misc_s1_q;
   logic [2:0]  misc_s2_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mon_s1_q  <= '0;
         mon_s2_q  <= '0;
         misc_s1_q <= '0;
         misc_s2_q <= '0;
      end else begin
         mon_s1_q  <= mon;
         mon_s2_q  <= mon_s1_q;
         misc_s1_q <= {osc_main_ok, sd_bit, sd_bit_valid};
         misc_s2_q <= misc_s1_q;
      end
   end

   logic rail_fail;
   assign rail_fail = !(mon_s2_q.analog_core_rail_ok && mon_s2_q.digital_core_rail_ok);

   // overtemperature filter counter
   logic [OTW-1:0] ot_cnt_q;
   logic           ot_fault;
   assign ot_fault = (ot_cnt_q == OTW'(OT_FLT_CYC));
   always_ff @(posedge clk) begin
      if (!rst_n || rail_fail || !mon_s2_q.overtemp_cmp)
         ot_cnt_q <= '0;
      else if (!ot_fault)
         ot_cnt_q <= ot_cnt_q + OTW'(1);
   end

   // supervisory state machine
   scts_state_t     state_q;
   logic [PUW-1:0]  pu_cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q  <= SCTS_ST_RESET;
         pu_cnt_q <= '0;
      end else if (rail_fail) begin
         state_q  <= SCTS_ST_RESET;
         pu_cnt_q <= '0;
      end else begin
         case (state_q)
            SCTS_ST_RESET: begin
               state_q  <= SCTS_ST_PWRUP;
               pu_cnt_q <= '0;
            end
            SCTS_ST_PWRUP: begin
               if (ot_fault)
                  state_q <= SCTS_ST_OT_SHUT;
               else if (pu_cnt_q == PUW'(PWRUP_CYC - 1))
                  state_q <= SCTS_ST_RUN;
               else
                  pu_cnt_q <= pu_cnt_q + PUW'(1);
            end
            SCTS_ST_RUN: begin
               if (ot_fault)
                  state_q <= SCTS_ST_OT_SHUT;
            end
            SCTS_ST_OT_SHUT: begin
               // wait for cooling below release before restarting
               if (mon_s2_q.overtemp_release && !mon_s2_q.overtemp_cmp) begin
                  state_q  <= SCTS_ST_PWRUP;
                  pu_cnt_q <= '0;
               end
            end
            default: state_q <= SCTS_ST_RESET;
         endcase
      end
   end

   // reset outputs share one condition so they can never disagree
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         primary_reset_out_n   <= 1'b0;
         secondary_reset_out_n <= 1'b0;
      end else begin
         primary_reset_out_n   <= !rail_fail && state_q != SCTS_ST_RESET;
         secondary_reset_out_n <= !rail_fail && state_q != SCTS_ST_RESET;
      end
   end

   // drivers and regulators: run state only, dropped on the cycle the filter trips
   always_ff @(posedge clk) begin
      if (!rst_n)
         outputs_enable <= 1'b0;
      else
         outputs_enable <= !rail_fail && !ot_fault && state_q == SCTS_ST_RUN;
   end

   // charge pump survives an overtemperature shutdown
   always_ff @(posedge clk) begin
      if (!rst_n)
         charge_pump_enable <= 1'b0;
      else
         charge_pump_enable <= !rail_fail && state_q != SCTS_ST_RESET;
   end

   // serial registers held while rails are bad or the state machine is in SCTS_ST_RESET
   always_ff @(posedge clk) begin
      if (!rst_n)
         regs_reset <= 1'b1;
      else
         regs_reset <= rail_fail || state_q == SCTS_ST_RESET;
   end

   // redundant oscillator select; the core clock mux lives in the analog macro
   always_ff @(posedge clk) begin
      if (!rst_n)
         osc_use_redundant <= 1'b0;
      else
         osc_use_redundant <= !misc_s2_q[2];
   end

   // triangular modulator: 64 levels up then down, 128 steps per sweep
   logic       ssm_up_q;
   always_ff @(posedge clk) begin
      if (!rst_n || ssm_disable) begin
         ssm_level <= 6'h20;
         ssm_up_q  <= 1'b1;
      end else if (ssm_up_q) begin
         if (ssm_level == 6'h3f)
            ssm_up_q <= 1'b0;
         else
            ssm_level <= ssm_level + 6'h01;
      end else begin
         if (ssm_level == 6'h00)
            ssm_up_q <= 1'b1;
         else
            ssm_level <= ssm_level - 6'h01;
      end
   end

   // sigma-delta decimation: count ones over 255 samples
   logic [7:0] sd_win_q;
   logic [7:0] sd_acc_q;
   logic [7:0] temp_code_q;
   logic       ot_flag_q;
   logic       sd_win_last;
   logic [7:0] sd_sample;
   assign sd_win_last = (sd_win_q == 8'hfe);
   assign sd_sample   = {7'h00, misc_s2_q[1]};
   always_ff @(posedge clk) begin
      if (!rst_n || regs_reset) begin
         sd_win_q <= '0;
         sd_acc_q <= '0;
      end else if (misc_s2_q[0]) begin
         if (sd_win_last) begin
            sd_win_q <= '0;
            sd_acc_q <= '0;
         end else begin
            sd_win_q <= sd_win_q + 8'h01;
            sd_acc_q <= sd_acc_q + sd_sample;
         end
      end
   end

   // code/255 spans full scale, matching the conversion formula
   always_ff @(posedge clk) begin
      if (!rst_n || regs_reset)
         temp_code_q <= `SCTS_TEMP_CODE_RST;
      else if (misc_s2_q[0] && sd_win_last)
         temp_code_q <= sd_acc_q + sd_sample;
   end

   // fault flag: set wins over read clear; cleared by rail reset (no sticky UV)
   always_ff @(posedge clk) begin
      if (!rst_n || rail_fail)
         ot_flag_q <= 1'b0;
      else if (ot_fault)
         ot_flag_q <= 1'b1;
      else if (temp_reg_read)
         ot_flag_q <= 1'b0;
   end

   // one register per field keeps each flop with a single writer
   assign temp_reg = '{die_overheat_fault: ot_flag_q, temperature_code: temp_code_q};
endmodule

// *** inc/scts_regs.svh ***
`ifndef SCTS_REGS_SVH
`define SCTS_REGS_SVH

// overtemperature filter, nominal and bounds in ns
`define SCTS_OT_FLT_NS       10000
`define SCTS_OT_FLT_MIN_NS   7500
`define SCTS_OT_FLT_MAX_NS   12500
`define SCTS_CLK_NS          100
// counts: nominal 10 us at 100 ns period
`define SCTS_OT_FLT_CYC      ((`SCTS_OT_FLT_NS + `SCTS_CLK_NS - 1) / `SCTS_CLK_NS)

// spread-spectrum modulator
`define SCTS_SSM_LEVELS      64
`define SCTS_SSM_HALF        32
`define SCTS_SSM_PERIOD      128
`define SCTS_SSM_STEP_PPM    1000

// temperature register layout
`define SCTS_TEMP_CODE_W     8
`define SCTS_TEMP_FAULT_BIT  8
`define SCTS_TEMP_CODE_RST   8'h00

// power-up sequence length in cycles
`define SCTS_PWRUP_CYC       16

`endif

// *** inc/scts_pkg.sv ***
package scts_pkg;
   typedef enum logic [3:0] {
      SCTS_ST_RESET   = 4'h1,
      SCTS_ST_PWRUP   = 4'h2,
      SCTS_ST_RUN     = 4'h4,
      SCTS_ST_OT_SHUT = 4'h8
   } scts_state_t;

   typedef struct packed {
      logic analog_core_rail_ok;
      logic digital_core_rail_ok;
      logic overtemp_cmp;
      logic overtemp_release;
   } scts_mon_t;

   typedef struct packed {
      logic       die_overheat_fault;
      logic [7:0] temperature_code;
   } scts_temp_reg_t;
endpackage

// *** tb/scts_asserts.sv ***
`timescale 1ns/10ps
module scts_asserts #(
   parameter int unsigned OT_FLT_CYC = 100,
   parameter int unsigned PWRUP_CYC  = 16
) (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire scts_pkg::scts_mon_t      mon,
   input wire logic                     osc_main_ok,
   input wire logic                     ssm_disable,
   input wire logic                     temp_reg_read,
   input wire logic                     primary_reset_out_n,
   input wire logic                     secondary_reset_out_n,
   input wire logic                     outputs_enable,
   input wire logic                     charge_pump_enable,
   input wire logic                     regs_reset,
   input wire logic                     osc_use_redundant,
   input wire logic [5:0]               ssm_level,
   input wire scts_pkg::scts_temp_reg_t temp_reg
);
   import scts_pkg::*;
   int unsigned hot_q;
   logic        rail_bad;
   assign rail_bad = !mon.analog_core_rail_ok || !mon.digital_core_rail_ok;
   // raw run length, leads the synced view by two cycles
   always_ff @(posedge clk) begin
      hot_q <= mon.overtemp_cmp ? hot_q + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rail_lost;
      rail_bad [*5];
   endsequence
   sequence s_hot;
      $rose(temp_reg.die_overheat_fault);
   endsequence
   chk_rail_por: assert property (s_rail_lost |-> !primary_reset_out_n && regs_reset)
      else $error("rail loss without reset");
   chk_reset_pair: assert property (primary_reset_out_n == secondary_reset_out_n)
      else $error("reset outputs differ");
   chk_por_off: assert property (!primary_reset_out_n |-> !outputs_enable && !charge_pump_enable)
      else $error("outputs on in reset");
   chk_ssm_hold: assert property (ssm_disable [*3] |-> ssm_level == 6'h20)
      else $error("modulator not centred");
   chk_ssm_step: assert property (!ssm_disable && $past(!ssm_disable) && outputs_enable &&
      $past(outputs_enable) |-> 6'(ssm_level - $past(ssm_level)) inside {6'h00, 6'h01, 6'h3f})
      else $error("modulator jumped");
   chk_ot_filter: assert property (s_hot |-> hot_q >= OT_FLT_CYC)
      else $error("overheat too early");
   chk_ot_late: assert property (hot_q == OT_FLT_CYC + 6 |-> !outputs_enable)
      else $error("overheat missed");
   chk_ot_pump: assert property (s_hot |-> ##[0:2] (!outputs_enable && charge_pump_enable))
      else $error("shutdown wrong");
   chk_read_clear: assert property (temp_reg_read && outputs_enable && !$past(mon.overtemp_cmp, 3) |->
      ##[1:2] !temp_reg.die_overheat_fault)
      else $error("flag not cleared");
   chk_osc_swap: assert property (!osc_main_ok [*5] |-> osc_use_redundant)
      else $error("no redundant clock");
endmodule
bind scts_supervisor scts_asserts #(.OT_FLT_CYC(OT_FLT_CYC), .PWRUP_CYC(PWRUP_CYC)) i_chk (.clk, .rst_n,
   .mon, .osc_main_ok, .ssm_disable, .temp_reg_read, .primary_reset_out_n, .secondary_reset_out_n,
   .outputs_enable, .charge_pump_enable, .regs_reset, .osc_use_redundant, .ssm_level, .temp_reg);

// *** tb/scts_host.sv ***
`timescale 1ns/10ps
module scts_host (
   input  wire logic                     clk,
   input  wire scts_pkg::scts_temp_reg_t temp_reg,
   output logic                          temp_reg_read,
   output logic                          ssm_disable
);
   initial begin
      temp_reg_read = 1'b0;
      ssm_disable   = 1'b0;
   end
   task automatic rd(output logic [8:0] v);
      @(negedge clk);
      temp_reg_read = 1'b1;
      // value standing at the edge that takes the read
      v = temp_reg;
      @(negedge clk);
      temp_reg_read = 1'b0;
   endtask
   task automatic ssm_off(input logic off);
      @(negedge clk);
      ssm_disable = off;
   endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import scts_pkg::*;
   logic           clk, rst_n, osc_ok, sd, sd_v, rd, dis, pr_n, sr_n, oe, cp, rr, red;
   logic [5:0]     lvl, mn, mx;
   logic [8:0]     v;
   scts_mon_t      mon;
   scts_temp_reg_t tr;
   int             fail_count, check_count, ones;
   logic           bits[$];
   logic [5:0]     lq[$];
   scts_supervisor #(.OT_FLT_CYC(5), .PWRUP_CYC(4)) i_dut (.clk(clk), .rst_n(rst_n), .mon(mon),
      .osc_main_ok(osc_ok), .sd_bit(sd), .sd_bit_valid(sd_v), .ssm_disable(dis), .temp_reg_read(rd),
      .primary_reset_out_n(pr_n), .secondary_reset_out_n(sr_n), .outputs_enable(oe),
      .charge_pump_enable(cp), .regs_reset(rr), .osc_use_redundant(red), .ssm_level(lvl), .temp_reg(tr));
   scts_host i_host (.clk(clk), .temp_reg(tr), .temp_reg_read(rd), .ssm_disable(dis));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // about 1160 cycles of tests, so 5000 means a hang
   initial begin
      #500000;
      fail_count++;
      test_done;
   end
   initial begin
      rst_n = 0; mon = 4'b1100; osc_ok = 1; sd = 0; sd_v = 1;
      void'($urandom(32'hb8e0));
      cyc(3); rst_n = 1; cyc(20);
      chk({pr_n, sr_n, oe, cp, rr}, 5'b11110);
      $display("test startup done");
      for (int i = 0; i < 255; i++) bits.push_back(1'($urandom));
      ones = 0;
      foreach (bits[i]) ones += bits[i];
      // periodic stream, so any 255-sample window holds the same count
      repeat (3) foreach (bits[i]) begin sd = bits[i]; cyc(1); end
      sd_v = 0; cyc(4); i_host.rd(v);
      chk(v, 9'(ones));
      $display("test temperature done");
      i_host.ssm_off(1); cyc(4);
      chk(lvl, 6'h20);
      i_host.ssm_off(0); cyc(2); mn = 6'h3f; mx = 6'h00;
      repeat (128) begin cyc(1); lq.push_back(lvl); if (lvl < mn) mn = lvl; if (lvl > mx) mx = lvl; end
      chk({mx, mn}, 12'hfc0);
      repeat (128) begin cyc(1); chk(lvl, lq.pop_front()); end
      $display("test modulator done");
      repeat (3) begin mon.overtemp_cmp = 1; cyc(4); mon.overtemp_cmp = 0; cyc(1); end
      chk(oe, 1);
      mon.overtemp_cmp = 1; cyc(14);
      chk({oe, cp, tr.die_overheat_fault}, 3'b011);
      mon.overtemp_cmp = 0; mon.overtemp_release = 1; cyc(14);
      chk(oe, 1);
      i_host.rd(v); cyc(2);
      chk({v[8], tr.die_overheat_fault}, 2'b10);
      mon.overtemp_release = 0;
      $display("test overheat done");
      for (int r = 0; r < 2; r++) begin
         mon[3 - r] = 0; cyc(8);
         chk({pr_n, sr_n, oe, cp, rr}, 5'b00001);
         mon[3 - r] = 1; cyc(16);
         chk({pr_n, sr_n, oe, rr}, 4'b1110);
      end
      $display("test rails done");
      osc_ok = 0; cyc(6);
      chk({red, oe}, 2'b11);
      $display("test oscillator done");
      test_done;
   end
endmodule
